// [vectored_irq_controller_cmds_tb_top.sv]
`timescale 1ns/100ps
module vectored_irq_controller_cmds_tb_top;
    import vic_pkg::*;
    logic        sys_clk;
    logic        rst;
    logic        wb_cyc;
    logic        wb_stb;
    logic        wb_we;
    logic [11:0] wb_adr;
    logic [31:0] wb_wdat;
    logic [31:0] wb_rdat;
    logic        wb_ack;
    logic        wb_err;
    logic [31:0] src_in;
    logic        fast_n;
    logic        normal_n;
    int          n_entries;
    int          f_entries;
    int          errors;
    int          cmp_count;
    logic [31:0] rd;
    logic        er;

    vic_ctrl i_dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .wb_err_o(wb_err), .src_in(src_in),
        .fast_request_line_n(fast_n), .normal_request_line_n(normal_n));
    vic_core_model i_core (.sys_clk(sys_clk), .rst(rst), .fast_request_line_n(fast_n),
        .normal_request_line_n(normal_n), .normal_entries(n_entries), .fast_entries(f_entries));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Classic single cycle; request held until ack or err is sampled high
    task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= we;
        wb_adr  <= adr;
        wb_wdat <= wd;
        @(posedge sys_clk);
        while (wb_ack !== 1'b1 && wb_err !== 1'b1 && n < 50) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 50) errors++;
        rd = wb_rdat;
        er = wb_err;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                       input string nm);
        wb(1'b0, a, 32'h0000_0000);
        chk(nm, rd & m, e);
    endtask

    // Lines are registered behind registered pending state, so let them land first
    task automatic lines(input logic f, input logic nr);
        repeat (4) @(posedge sys_clk);
        chk("fast_line", {31'h0, fast_n}, {31'h0, f});
        chk("normal_line", {31'h0, normal_n}, {31'h0, nr});
    endtask

    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog sized well above the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        complete_run();
    end

    initial begin
        errors = 0;
        cmp_count = 0;
        rst = 1'b1;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 12'h000;
        wb_wdat = 32'h0000_0000;
        src_in = 32'hf000_0000; // External low-level inputs held inactive
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        lines(1'b1, 1'b1);
        rdc(OFF_SPU, 32'hffff_ffff, 32'h0000_0000, "spu_reset");
        rdc(OFF_IMR, 32'hffff_ffff, 32'h0000_0000, "mask_reset");
        rdc(OFF_CISR, 32'hffff_ffff, 32'h0000_0000, "cisr_idle");
        wb(1'b1, OFF_SPU, 32'hdead_beef);
        rdc(OFF_SPU, 32'hffff_ffff, 32'hdead_beef, "spu_rw");
        rdc(OFF_IVR, 32'hffff_ffff, 32'hdead_beef, "ivr_spurious");
        wb(1'b0, 12'h118, 32'h0000_0000);
        chk("unmapped_err", {31'h0, er}, 32'h1);
        $display("test reset_and_spurious done");
        // Sources 2,3,4 edge triggered at priorities 2,5,4
        for (int s = 2; s <= 4; s++) begin
            wb(1'b1, OFF_SMR_BASE + 12'(4 * s), 32'h20 | (s == 2 ? 2 : (s == 3 ? 5 : 4)));
            wb(1'b1, OFF_SVR_BASE + 12'(4 * s), 32'h1000_0000 | s);
        end
        wb(1'b1, OFF_ISCR, 32'h0000_0004);
        lines(1'b1, 1'b1);
        wb(1'b1, OFF_IECR, 32'h0000_001c);
        wb(1'b1, OFF_IECR, 32'h0000_0000);
        rdc(OFF_IMR, 32'hffff_ffff, 32'h0000_001c, "mask_enable");
        lines(1'b1, 1'b0);
        rdc(OFF_CISR, 32'hffff_ffff, 32'h0000_0002, "cisr_normal");
        rdc(OFF_IVR, 32'hffff_ffff, 32'h1000_0002, "ivr_src2");
        chk("normal_after_ivr", {31'h0, normal_n}, 32'h1);
        rdc(OFF_IPR, 32'h0000_0004, 32'h0000_0000, "edge_autoclear");
        wb(1'b1, OFF_ISCR, 32'h0000_0008);
        lines(1'b1, 1'b0);
        rdc(OFF_IVR, 32'hffff_ffff, 32'h1000_0003, "ivr_nested");
        wb(1'b1, OFF_ISCR, 32'h0000_0010);
        lines(1'b1, 1'b1);
        wb(1'b1, OFF_EOICR, 32'h1234_5678);
        lines(1'b1, 1'b0);
        rdc(OFF_IVR, 32'hffff_ffff, 32'h1000_0004, "ivr_after_pop");
        wb(1'b1, OFF_EOICR, 32'h0000_0000);
        wb(1'b1, OFF_EOICR, 32'hffff_ffff);
        lines(1'b1, 1'b1);
        chk("core_entries", n_entries, 32'h3);
        $display("test nesting done");
        wb(1'b1, OFF_IDCR, 32'h0000_0004);
        rdc(OFF_IMR, 32'hffff_ffff, 32'h0000_0018, "mask_disable");
        wb(1'b1, OFF_ISCR, 32'h0000_0008);
        wb(1'b1, OFF_ICCR, 32'h0000_0008);
        lines(1'b1, 1'b1);
        rdc(OFF_IPR, 32'h0000_0008, 32'h0000_0000, "pending_clear");
        $display("test disable_clear done");
        // Level source 5 at priority 1: handler drops it before ending service
        wb(1'b1, OFF_SMR_BASE + 12'h014, 32'h0000_0001);
        wb(1'b1, OFF_IECR, 32'h0000_0020);
        src_in[5] <= 1'b1;
        lines(1'b1, 1'b0);
        rdc(OFF_IVR, 32'hffff_ffff, 32'h0000_0000, "ivr_level");
        lines(1'b1, 1'b1);
        src_in[5] <= 1'b0;
        wb(1'b1, OFF_EOICR, 32'h0000_0000);
        lines(1'b1, 1'b1);
        wb(1'b1, OFF_IDCR, 32'h0000_0020);
        $display("test level_source done");
        // Priority bits set on source 0 must not matter
        wb(1'b1, OFF_SMR_BASE, 32'h0000_0027);
        wb(1'b1, OFF_SVR_BASE, 32'hf00d_0000);
        wb(1'b1, OFF_IECR, 32'h0000_0001);
        wb(1'b1, OFF_ISCR, 32'h0000_0001);
        lines(1'b0, 1'b1);
        rdc(OFF_CISR, 32'hffff_ffff, 32'h0000_0001, "cisr_fast");
        rdc(OFF_FVR, 32'hffff_ffff, 32'hf00d_0000, "fvr_edge");
        lines(1'b1, 1'b1);
        wb(1'b1, OFF_SMR_BASE, 32'h0000_0000);
        src_in[0] <= 1'b1;
        lines(1'b0, 1'b1);
        rdc(OFF_FVR, 32'hffff_ffff, 32'hf00d_0000, "fvr_level");
        lines(1'b0, 1'b1);
        src_in[0] <= 1'b0;
        wb(1'b1, OFF_ICCR, 32'h0000_0001);
        lines(1'b1, 1'b1);
        chk("fast_entries", f_entries, 32'h2);
        $display("test fast done");
        // External input 0 on bit 28 as rising edge
        wb(1'b1, OFF_SMR_BASE + 12'h070, 32'h0000_0060);
        src_in[28] <= 1'b0;
        rdc(OFF_IPR, 32'h1000_0000, 32'h0000_0000, "ext_no_fall");
        src_in[28] <= 1'b1;
        rdc(OFF_IPR, 32'h1000_0000, 32'h1000_0000, "ext_rise");
        wb(1'b1, OFF_ICCR, 32'h1000_0000);
        rdc(OFF_IPR, 32'h1000_0000, 32'h0000_0000, "ext_clear");
        $display("test external_edge done");
        complete_run();
    end
endmodule

// [vic_core_model.sv]
`timescale 1ns/100ps
// Core side of the request lines; the bench plays the software that reads vectors and ends service
module vic_core_model (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic fast_request_line_n,
    input  wire logic normal_request_line_n,
    output int        normal_entries,
    output int        fast_entries
);
    logic nrm_ff;
    logic fst_ff;

    // Count each entry into a handler; a held-low line is one entry, so a missing deassert shows
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            nrm_ff         <= 1'b1;
            fst_ff         <= 1'b1;
            normal_entries <= 0;
            fast_entries   <= 0;
        end else begin
            nrm_ff <= normal_request_line_n;
            fst_ff <= fast_request_line_n;
            if (nrm_ff && !normal_request_line_n) normal_entries <= normal_entries + 1;
            if (fst_ff && !fast_request_line_n) fast_entries <= fast_entries + 1;
        end
    end
endmodule

// [vic_ctrl.sv]
// Our own choice: register access over Wishbone.
`timescale 1ns/100ps
module vic_ctrl (
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [11:0]            wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic [31:0]                 wb_dat_o,
    output logic                        wb_ack_o,
    output logic                        wb_err_o,
    input  wire logic [vic_pkg::NSRC-1:0] src_in,
    output logic                        fast_request_line_n,
    output logic                        normal_request_line_n
);
    import vic_pkg::*;

    vic_vec_if vec ();
    vic_vec_mem u_mem (.sys_clk(sys_clk), .rst(rst), .port(vec.mem));

    logic [7:0]            mode_ff [NSRC];
    logic [NSRC-1:0]       mask_ff, pend_ff, src_d_ff;
    logic [31:0]           spu_ff, rdat_ff;
    logic                  irq_ff, fiq_ff, ack_ff, err_ff;
    logic [SRC_W-1:0]      cur_ff;
    logic                  cur_valid_ff;
    logic [PRI_W-1:0]      stk_ff [STK_DEPTH];
    logic [SRC_W-1:0]      stk_src_ff [STK_DEPTH];
    logic [3:0]            sp_ff;
    vic_bus_type           bus_ff;
    logic                  use_spu_ff;

    // Word-merge under byte enables
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) r[b*8 +: 8] = nw[b*8 +: 8];
        end
        return r;
    endfunction

    function automatic logic is_edge(input logic [7:0] m);
        return m[SMR_TYPE_LSB];
    endfunction

    // Bus decode
    wire req      = wb_cyc_i & wb_stb_i & (bus_ff == BUS_IDLE);
    wire wr       = req & wb_we_i;
    wire rd       = req & ~wb_we_i;
    wire a_smr    = wb_adr_i < OFF_SVR_BASE;
    wire a_svr    = (wb_adr_i >= OFF_SVR_BASE) && (wb_adr_i < OFF_IVR);
    wire [SRC_W-1:0] a_idx = wb_adr_i[SRC_W+1:2];
    wire a_unm    = ((wb_adr_i >= 12'h118) && (wb_adr_i < OFF_IECR)) || (wb_adr_i > OFF_SPU)
                    || (wb_adr_i[1:0] != 2'h0);
    wire rd_ivr   = rd & (wb_adr_i == OFF_IVR);
    wire rd_fvr   = rd & (wb_adr_i == OFF_FVR);
    wire wr_eoi   = wr & (wb_adr_i == OFF_EOICR);
    wire [NSRC-1:0] wmask = wb_dat_i & SRC_USED;
    // Mode word after byte-enable merge; only the low byte is kept
    wire [31:0] mode_wr = merge({24'h0, mode_ff[a_idx]}, wb_dat_i, wb_sel_i);

    // Raw request per source with polarity for external inputs
    logic [NSRC-1:0] lvl, edg, raw;
    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            if (i >= EXT_LO && ~mode_ff[i][SMR_TYPE_LSB+1]) begin
                lvl[i] = ~src_in[i];
                edg[i] = src_d_ff[i] & ~src_in[i];
            end else begin
                lvl[i] = src_in[i];
                edg[i] = ~src_d_ff[i] & src_in[i];
            end
            raw[i] = is_edge(mode_ff[i]) ? edg[i] : lvl[i];
        end
    end

    // Effective pending: edge latched, level live
    logic [NSRC-1:0] eff;
    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            eff[i] = is_edge(mode_ff[i]) ? pend_ff[i] : (pend_ff[i] | lvl[i]);
        end
    end
    wire [NSRC-1:0] act = eff & mask_ff & SRC_USED;

    // Highest priority pending normal source, lowest number on a tie
    logic [SRC_W-1:0] best;
    logic [PRI_W-1:0] best_pri;
    logic             best_ok;
    always_comb begin
        best = '0;
        best_pri = '0;
        best_ok = 1'b0;
        for (int i = NSRC - 1; i >= 1; i--) begin
            if (act[i] && (!best_ok || mode_ff[i][PRI_W-1:0] >= best_pri)) begin
                best = SRC_W'(i);
                best_pri = mode_ff[i][SMR_PRI_LSB +: PRI_W];
                best_ok = 1'b1;
            end
        end
    end

    wire [PRI_W-1:0] cur_lvl = stk_ff[sp_ff[2:0] - 3'h1];
    wire in_service  = sp_ff != 4'h0;
    // Request when idle, or when strictly above current level
    wire nxt_irq = best_ok && (!in_service || best_pri > cur_lvl);
    wire nxt_fiq = act[FIQ_SRC];

    // Mode, mask, spurious and edge history
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < NSRC; i++) mode_ff[i] <= 8'h00;
            mask_ff  <= '0;
            spu_ff   <= SPU_RESET;
            src_d_ff <= '0;
        end else begin
            src_d_ff <= src_in;
            if (wr & a_smr) mode_ff[a_idx] <= mode_wr[7:0];
            if (wr && wb_adr_i == OFF_IECR) mask_ff <= mask_ff | wmask;
            if (wr && wb_adr_i == OFF_IDCR) mask_ff <= mask_ff & ~wmask;
            if (wr && wb_adr_i == OFF_SPU) spu_ff <= merge(spu_ff, wb_dat_i, wb_sel_i);
        end
    end

    // Pending latch; a new edge wins over any clear in the same cycle
    logic [NSRC-1:0] clr;
    always_comb begin
        clr = '0;
        if (wr && wb_adr_i == OFF_ICCR) clr = wmask;
        if (rd_ivr && best_ok && is_edge(mode_ff[best])) clr[best] = 1'b1;
        if (rd_fvr && is_edge(mode_ff[FIQ_SRC])) clr[FIQ_SRC] = 1'b1;
    end
    // Edge-mode select per source; a process so mode changes are seen at once
    logic [NSRC-1:0] edg_sel;
    always_comb begin
        edg_sel = '0;
        for (int i = 0; i < NSRC; i++) edg_sel[i] = is_edge(mode_ff[i]);
    end
    wire [NSRC-1:0] setv = (raw & edg_sel) | ((wr && wb_adr_i == OFF_ISCR)
                           ? wmask : '0);

    always_ff @(posedge sys_clk) begin
        if (rst) pend_ff <= '0;
        else pend_ff <= (pend_ff & ~clr) | setv;
    end

    // Level stack: push on normal vector read, pop on end of service
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sp_ff <= 4'h0;
            cur_valid_ff <= 1'b0;
            cur_ff <= '0;
            for (int i = 0; i < STK_DEPTH; i++) begin
                stk_ff[i] <= '0;
                stk_src_ff[i] <= '0;
            end
        end else if (rd_ivr && best_ok && sp_ff < 4'(STK_DEPTH)) begin
            stk_ff[sp_ff[2:0]] <= best_pri;
            stk_src_ff[sp_ff[2:0]] <= best;
            sp_ff <= sp_ff + 4'h1;
            cur_ff <= best;
            cur_valid_ff <= 1'b1;
        end else if (wr_eoi && in_service) begin
            sp_ff <= sp_ff - 4'h1;
            cur_valid_ff <= sp_ff > 4'h1;
            cur_ff <= (sp_ff > 4'h1) ? stk_src_ff[sp_ff[2:0] - 3'h2] : '0;
        end
    end

    // Request lines: normal line drops on vector read, else follows arbitration
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_ff <= 1'b0;
            fiq_ff <= 1'b0;
        end else begin
            irq_ff <= rd_ivr ? 1'b0 : nxt_irq;
            fiq_ff <= nxt_fiq & ~(rd_fvr & is_edge(mode_ff[FIQ_SRC]));
        end
    end
    assign normal_request_line_n = ~irq_ff;
    assign fast_request_line_n   = ~fiq_ff;

    // Vector store ports
    assign vec.we    = wr & a_svr;
    assign vec.waddr = a_idx;
    assign vec.wdata = wb_dat_i;
    assign vec.raddr = rd_ivr ? best : (rd_fvr ? SRC_W'(FIQ_SRC) : a_idx);

    // Bus sequencer: read data settles one cycle after the memory read
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bus_ff <= BUS_IDLE;
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
            rdat_ff <= ZERO32;
            use_spu_ff <= 1'b0;
        end else begin
            case (bus_ff)
                BUS_IDLE: begin
                    if (req) begin
                        bus_ff <= BUS_WAIT;
                        use_spu_ff <= rd_ivr & ~best_ok;
                        rdat_ff <= (wb_adr_i == OFF_ISR) ? {27'h0, cur_ff}
                                 : (wb_adr_i == OFF_IPR) ? (eff & SRC_USED)
                                 : (wb_adr_i == OFF_IMR) ? mask_ff
                                 : (wb_adr_i == OFF_CISR) ? {30'h0, irq_ff, fiq_ff}
                                 : (wb_adr_i == OFF_SPU) ? spu_ff
                                 : a_smr ? {24'h0, mode_ff[a_idx]} : ZERO32;
                        err_ff <= a_unm;
                    end
                end
                BUS_WAIT: begin
                    bus_ff <= BUS_ACK;
                    ack_ff <= 1'b1;
                end
                BUS_ACK: begin
                    bus_ff <= BUS_IDLE;
                    ack_ff <= 1'b0;
                    err_ff <= 1'b0;
                end
                default: bus_ff <= BUS_IDLE;
            endcase
        end
    end

    // Late mux picks memory data for vector reads
    logic is_vec_ff;
    always_ff @(posedge sys_clk) begin
        if (rst) is_vec_ff <= 1'b0;
        else if (req) is_vec_ff <= rd & (a_svr | wb_adr_i == OFF_IVR | wb_adr_i == OFF_FVR);
    end
    always_ff @(posedge sys_clk) begin
        if (rst) wb_dat_o <= ZERO32;
        else if (bus_ff == BUS_WAIT)
            wb_dat_o <= use_spu_ff ? spu_ff : (is_vec_ff ? vec.rdata : rdat_ff);
    end
    assign wb_ack_o = ack_ff & ~err_ff;
    assign wb_err_o = ack_ff & err_ff;

    // Masked fast source may never raise the fast request line
    masked_fiq_a: assert property (@(posedge sys_clk) disable iff (rst)
        !mask_ff[FIQ_SRC] |=> !fiq_ff) else $error("masked fast source requested");
    ivr_drop_a: assert property (@(posedge sys_clk) disable iff (rst)
        rd_ivr |=> !irq_ff) else $error("normal line held after vector read");
    push_depth_a: assert property (@(posedge sys_clk) disable iff (rst)
        rd_ivr && best_ok && sp_ff < 4'h8 |=> sp_ff == $past(sp_ff) + 4'h1)
        else $error("stack not pushed");
    pop_depth_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_eoi && in_service && !rd_ivr |=> sp_ff == $past(sp_ff) - 4'h1)
        else $error("stack not popped");
    enable_cmd_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr && wb_adr_i == OFF_IECR |=> (mask_ff & $past(wmask)) == $past(wmask))
        else $error("enable lost");
    disable_cmd_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr && wb_adr_i == OFF_IDCR |=> (mask_ff & $past(wmask)) == '0)
        else $error("disable lost");
    set_cmd_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr && wb_adr_i == OFF_ISCR |=> (pend_ff & $past(wmask)) == $past(wmask))
        else $error("set lost");
    status_lines_a: assert property (@(posedge sys_clk) disable iff (rst)
        rd && wb_adr_i == OFF_CISR |=> rdat_ff[CISR_IRQ_BIT] == $past(irq_ff)
        && rdat_ff[CISR_FIQ_BIT] == $past(fiq_ff)) else $error("line status mismatch");
    nest_req_a: assert property (@(posedge sys_clk) disable iff (rst)
        nxt_irq && !rd_ivr |=> irq_ff) else $error("nesting request lost");
endmodule

// [vic_pkg.sv]
// Overview of operation
// - Status register shows fast and normal line activity
// - Clear command clears pending bits written one
// - Set command forces pending bits written one
// - One bit per source, fixed source positions
// - Any end-of-service write ends current service
// - Spurious vector full-width read-write, resets zero
// - Normal vector read selects highest pending source
// - Normal vector read deasserts normal request line
// - Normal vector read clears edge source pending
// - Normal vector read pushes level, returns vector
// - Returned vector indexed by current source number
// - Higher priority pending source reasserts normal line
// - End-of-service pops stack, restores previous level
// - After pop, higher than restored level reasserts
// - Fast vector read clears edge source zero
// - No current interrupt returns spurious vector
// - Three-bit priority, ignored for fast source
// - Trigger type encodes level or edge polarity
// - Mask resets zero, masked sources never request
package vic_pkg;
    localparam int NSRC = 32;
    localparam int SRC_W = 5;
    localparam int PRI_W = 3;
    localparam int STK_DEPTH = 8;
    // Register byte offsets
    localparam logic [11:0] OFF_SMR_BASE = 12'h000; // Mode words 0x000..0x07c
    localparam logic [11:0] OFF_SVR_BASE = 12'h080; // Vector words 0x080..0x0fc
    localparam logic [11:0] OFF_IVR = 12'h100;
    localparam logic [11:0] OFF_FVR = 12'h104;
    localparam logic [11:0] OFF_ISR = 12'h108;
    localparam logic [11:0] OFF_IPR = 12'h10c;
    localparam logic [11:0] OFF_IMR = 12'h110;
    localparam logic [11:0] OFF_CISR = 12'h114;
    localparam logic [11:0] OFF_IECR = 12'h120;
    localparam logic [11:0] OFF_IDCR = 12'h124;
    localparam logic [11:0] OFF_ICCR = 12'h128;
    localparam logic [11:0] OFF_ISCR = 12'h12c;
    localparam logic [11:0] OFF_EOICR = 12'h130;
    localparam logic [11:0] OFF_SPU = 12'h134;
    // Field positions
    localparam int CISR_FIQ_BIT = 0;
    localparam int CISR_IRQ_BIT = 1;
    localparam int SMR_PRI_LSB = 0;
    localparam int SMR_TYPE_LSB = 5;
    localparam int FIQ_SRC = 0;
    localparam int EXT_LO = 28;
    localparam logic [31:0] SRC_USED = 32'hf000_ffff;
    localparam logic [31:0] SPU_RESET = 32'h0000_0000;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    typedef enum logic [1:0] {
        TRG_LOW_LEVEL  = 2'h0,
        TRG_FALL_EDGE  = 2'h1,
        TRG_HIGH_LEVEL = 2'h2,
        TRG_RISE_EDGE  = 2'h3
    } vic_trig_type;
    typedef enum logic [2:0] {
        BUS_IDLE = 3'h1,
        BUS_ACK  = 3'h2,
        BUS_WAIT = 3'h4
    } vic_bus_type;
endpackage

// [vic_vec_if.sv]
`timescale 1ns/100ps
// Vector memory access shared between the top and its vector store
interface vic_vec_if;
    import vic_pkg::*;
    logic              we;
    logic [SRC_W-1:0]  waddr;
    logic [31:0]       wdata;
    logic [SRC_W-1:0]  raddr;
    logic [31:0]       rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// [vic_vec_mem.sv]
`timescale 1ns/100ps
// Per-source vector store, registered read data
module vic_vec_mem (
    input  wire logic  sys_clk,
    input  wire logic  rst,
    vic_vec_if.mem     port
);
    import vic_pkg::*;
    logic [31:0] mem_ff [NSRC];

    // Write port, vectors reset to zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < NSRC; i++) begin
                mem_ff[i] <= ZERO32;
            end
        end else if (port.we) begin
            mem_ff[port.waddr] <= port.wdata;
        end
    end

    // Read data out of a register, one cycle after the address
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            port.rdata <= ZERO32;
        end else begin
            port.rdata <= mem_ff[port.raddr];
        end
    end
endmodule
